// ### core/wtc_trigger_ctrl.sv
`timescale 1ns/1ps
`include "wtc_map.svh"
module wtc_trigger_ctrl #(
    parameter logic [22:0] DELAY_MAX     = 23'(`WTC_DELAY_MAX),
    parameter logic [22:0] RETRIG_MAX    = 23'(`WTC_RETRIG_MAX),
    parameter logic [19:0] BURST_MAX     = 20'(`WTC_BURST_MAX),
    parameter logic [27:0] TIMER_MAX_CYC = 28'(`WTC_TIMER_MAX_CYC),
    parameter int          WIDTH_W       = 16
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  trig_in_pin,
    input  wire logic                  event_in_pin,
    input  wire logic                  manual_trigger_button,
    input  wire logic                  bus_trigger,
    input  wire wtc_pkg::wtc_run_t     run_mode,
    input  wire wtc_pkg::wtc_src_t     src_sel,
    input  wire wtc_pkg::wtc_edge_t    trig_edge,
    input  wire logic                  event_fall,
    input  wire logic                  arm_en,
    input  wire logic                  override_en,
    input  wire logic                  seq_playing,
    input  wire wtc_pkg::wtc_width_t   width_mode,
    input  wire logic [WIDTH_W-1:0]    width_lo,
    input  wire logic [WIDTH_W-1:0]    width_hi,
    input  wire logic                  holdoff_en,
    input  wire logic [22:0]           holdoff_cycles,
    input  wire logic [22:0]           start_delay,
    input  wire wtc_pkg::wtc_tmode_t   timer_mode,
    input  wire logic [27:0]           timer_period,
    input  wire logic [22:0]           retrig_delay,
    input  wire logic [19:0]           burst_count,
    input  wire logic                  cycle_done,
    output logic                       wave_start_r,
    output logic                       playing_r,
    output logic                       out_enable_r,
    output logic                       hold_last_r
);
    import wtc_pkg::*;

    localparam logic [27:0] TIMER_MIN_CYC = 28'(`WTC_TIMER_MIN_CYC);
    localparam logic [22:0] RETRIG_MIN    = 23'(`WTC_RETRIG_MIN);
    localparam logic [19:0] BURST_MIN     = 20'(`WTC_BURST_MIN);

    logic [2:0]  sync1_r;
    logic [2:0]  sync2_r;
    logic        man_prev_r;
    logic        external_source_select;
    logic        trig_en;
    logic        evt_en;
    logic        man_en;
    logic        bus_en;
    logic        tim_en;
    logic        trig_hit;
    logic        evt_hit;
    logic        man_hit;
    logic        bus_hit;
    logic        tim_hit;
    wtc_edge_t   evt_edge;
    logic [27:0] tim_period;
    logic [27:0] tim_cnt_r;
    logic [27:0] tim_cnt_nxt;
    logic        tim_run;
    logic        trig_mode;
    logic        acc_any;
    logic        delay_src;
    logic        hold_src;
    logic        ovr_ok;
    logic        retrig_on;
    logic        kick;
    logic [22:0] dly_eff;
    logic [22:0] rtg_eff;
    logic [19:0] burst_eff;
    wtc_state_t  go_st;
    logic        go_start;
    wtc_state_t  st_r;
    wtc_state_t  st_nxt;
    logic [22:0] cnt_r;
    logic [22:0] cnt_nxt;
    logic [19:0] burst_r;
    logic [19:0] burst_nxt;
    logic        start_nxt;
    logic        playing_nxt;
    logic        cont_rel_r;
    logic        cont_rel_nxt;
    logic        gate_r;
    logic        gate_nxt;
    logic        out_en_nxt;

    // Pins and the button are asynchronous to the sample clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_r    <= 3'h0;
            sync2_r    <= 3'h0;
            man_prev_r <= 1'b0;
        end else begin
            sync1_r    <= {manual_trigger_button, event_in_pin, trig_in_pin};
            sync2_r    <= sync1_r;
            man_prev_r <= sync2_r[2];
        end
    end

    always_comb begin
        external_source_select = (src_sel == WTC_SRC_EXT);
        trig_en   = external_source_select;
        evt_en    = (src_sel == WTC_SRC_EVENT);
        man_en    = external_source_select && (run_mode == WTC_RUN_TRIG);
        bus_en    = (src_sel == WTC_SRC_BUS) && (run_mode != WTC_RUN_GATE);
        tim_en    = (src_sel == WTC_SRC_TIMER) && (run_mode == WTC_RUN_TRIG);
        evt_edge  = event_fall ? WTC_EDGE_FALL : WTC_EDGE_RISE;
        man_hit   = man_en && sync2_r[2] && !man_prev_r;
        bus_hit   = bus_en && bus_trigger;
    end

    wtc_width_qual #(.W(WIDTH_W)) u_trig_qual (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .en         (trig_en),
        .sig        (sync2_r[0]),
        .edge_sel   (trig_edge),
        .width_mode (width_mode),
        .width_lo   (width_lo),
        .width_hi   (width_hi),
        .hit_r      (trig_hit)
    );

    // Width qualification is not offered on the event input
    wtc_width_qual #(.W(WIDTH_W)) u_evt_qual (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .en         (evt_en),
        .sig        (sync2_r[1]),
        .edge_sel   (evt_edge),
        .width_mode (WTC_WID_OFF),
        .width_lo   ({WIDTH_W{1'b0}}),
        .width_hi   ({WIDTH_W{1'b0}}),
        .hit_r      (evt_hit)
    );

    // Limits are clamped here rather than trusted from the control side
    always_comb begin
        if (timer_period < TIMER_MIN_CYC) begin
            tim_period = TIMER_MIN_CYC;
        end else if (timer_period > TIMER_MAX_CYC) begin
            tim_period = TIMER_MAX_CYC;
        end else begin
            tim_period = timer_period;
        end
        dly_eff   = (start_delay > DELAY_MAX) ? DELAY_MAX : start_delay;
        if (retrig_delay < RETRIG_MIN) begin
            rtg_eff = RETRIG_MIN;
        end else if (retrig_delay > RETRIG_MAX) begin
            rtg_eff = RETRIG_MAX;
        end else begin
            rtg_eff = retrig_delay;
        end
        if (burst_count < BURST_MIN) begin
            burst_eff = BURST_MIN;
        end else if (burst_count > BURST_MAX) begin
            burst_eff = BURST_MAX;
        end else begin
            burst_eff = burst_count;
        end
    end

    // Free-running start-to-start generator; ticks during playback are dropped
    always_comb begin
        tim_run = tim_en && (timer_mode == WTC_TMR_START);
        tim_hit = tim_run && (tim_cnt_r == 28'h1);
        if (!tim_run) begin
            tim_cnt_nxt = tim_period;
        end else if (tim_cnt_r <= 28'h1) begin
            tim_cnt_nxt = tim_period;
        end else begin
            tim_cnt_nxt = tim_cnt_r - 28'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tim_cnt_r <= 28'h0;
        end else begin
            tim_cnt_r <= tim_cnt_nxt;
        end
    end

    // Per-source features of the triggered engine
    always_comb begin
        trig_mode = (run_mode == WTC_RUN_TRIG);
        acc_any   = trig_mode && (trig_hit || man_hit || bus_hit || evt_hit || tim_hit);
        delay_src = trig_hit || man_hit || bus_hit;
        hold_src  = (trig_hit || bus_hit) && holdoff_en;
        ovr_ok    = (trig_hit || man_hit || bus_hit) && override_en && !seq_playing;
        retrig_on = ((src_sel == WTC_SRC_EVENT) || (src_sel == WTC_SRC_TIMER))
                    && (timer_mode == WTC_TMR_STOP);
        kick      = tim_en && (timer_mode == WTC_TMR_STOP);
        go_start  = !(delay_src && (dly_eff != 23'h0));
        go_st     = go_start ? WTC_ST_PLAY : WTC_ST_DELAY;
    end

    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        burst_nxt = burst_r;
        start_nxt = 1'b0;
        unique case (st_r)
            WTC_ST_IDLE: begin
                if (acc_any && hold_src) begin
                    st_nxt  = (holdoff_cycles != 23'h0) ? WTC_ST_HOLD : WTC_ST_ARMED;
                    cnt_nxt = holdoff_cycles;
                end else if (acc_any) begin
                    st_nxt    = go_st;
                    cnt_nxt   = dly_eff;
                    burst_nxt = burst_eff;
                    start_nxt = go_start;
                end else if (kick) begin
                    st_nxt    = WTC_ST_PLAY;
                    burst_nxt = burst_eff;
                    start_nxt = 1'b1;
                end
            end
            WTC_ST_HOLD: begin
                if (acc_any && ovr_ok) begin
                    cnt_nxt = holdoff_cycles;
                end else if (cnt_r <= 23'h1) begin
                    st_nxt = WTC_ST_ARMED;
                end else begin
                    cnt_nxt = cnt_r - 23'h1;
                end
            end
            WTC_ST_ARMED: begin
                if (acc_any) begin
                    st_nxt    = go_st;
                    cnt_nxt   = dly_eff;
                    burst_nxt = burst_eff;
                    start_nxt = go_start;
                end
            end
            WTC_ST_DELAY, WTC_ST_GAP: begin
                if ((st_r == WTC_ST_DELAY) && acc_any && ovr_ok) begin
                    cnt_nxt = dly_eff;
                end else if (cnt_r <= 23'h1) begin
                    st_nxt    = WTC_ST_PLAY;
                    burst_nxt = burst_eff;
                    start_nxt = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 23'h1;
                end
            end
            WTC_ST_PLAY: begin
                if (acc_any && ovr_ok) begin
                    st_nxt    = go_st;
                    cnt_nxt   = dly_eff;
                    burst_nxt = burst_eff;
                    start_nxt = go_start;
                end else if (cycle_done && (burst_r > 20'h1)) begin
                    burst_nxt = burst_r - 20'h1;
                    start_nxt = 1'b1;
                end else if (cycle_done && retrig_on) begin
                    st_nxt  = WTC_ST_GAP;
                    cnt_nxt = rtg_eff;
                end else if (cycle_done) begin
                    st_nxt = WTC_ST_IDLE;
                end
            end
            default: st_nxt = WTC_ST_IDLE;
        endcase
        playing_nxt = (st_nxt == WTC_ST_PLAY);
    end

    // Continuous-armed release takes trigger, event and bus hits; gated level toggles on trigger and event hits only
    always_comb begin
        cont_rel_nxt = (run_mode == WTC_RUN_CONT) && arm_en
                       && (cont_rel_r || trig_hit || evt_hit || bus_hit);
        gate_nxt     = (run_mode == WTC_RUN_GATE) ? (gate_r ^ (trig_hit || evt_hit)) : 1'b0;
        unique case (run_mode)
            WTC_RUN_CONT: out_en_nxt = !arm_en || cont_rel_nxt;
            WTC_RUN_TRIG: out_en_nxt = playing_nxt;
            WTC_RUN_GATE: out_en_nxt = gate_nxt;
            default:      out_en_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r         <= wtc_state_t'(`WTC_RST_STATE);
            cnt_r        <= 23'h0;
            burst_r      <= 20'h0;
            wave_start_r <= 1'b0;
            playing_r    <= 1'b0;
            cont_rel_r   <= 1'b0;
            gate_r       <= 1'b0;
            out_enable_r <= 1'b0;
            hold_last_r  <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            cnt_r        <= cnt_nxt;
            burst_r      <= burst_nxt;
            wave_start_r <= start_nxt;
            playing_r    <= playing_nxt;
            cont_rel_r   <= cont_rel_nxt;
            gate_r       <= gate_nxt;
            out_enable_r <= out_en_nxt;
            hold_last_r  <= trig_mode && !playing_nxt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_delay_count: assert property ((st_r == WTC_ST_DELAY) && (cnt_r == 23'h3) && !override_en
        |-> !wave_start_r [*3] ##1 wave_start_r)
        else $error("start delay did not expire after three cycles");

    a_normal_ignore: assert property ((st_r == WTC_ST_PLAY) && acc_any && !ovr_ok && !cycle_done
        |=> !wave_start_r && (st_r == WTC_ST_PLAY))
        else $error("trigger disturbed a playing cycle in normal mode");

    a_override_go: assert property ((st_r == WTC_ST_PLAY) && acc_any && ovr_ok && go_start
        |=> wave_start_r && (burst_r == $past(burst_eff)))
        else $error("override trigger did not restart the waveform");

    a_seq_no_ovr: assert property ((st_r == WTC_ST_PLAY) && seq_playing && !cycle_done
        |=> !wave_start_r)
        else $error("override acted while a sequence was playing");

    a_retrig_gap: assert property ((st_r == WTC_ST_PLAY) && cycle_done && (burst_r == 20'h1)
        && retrig_on && !(acc_any && ovr_ok) |=> !wave_start_r [*8])
        else $error("re-trigger started sooner than its minimum gap");

    a_burst_step: assert property ((st_r == WTC_ST_PLAY) && cycle_done && (burst_r > 20'h1)
        && !(acc_any && ovr_ok) |=> wave_start_r && (burst_r == $past(burst_r) - 20'h1))
        else $error("burst did not advance to the next cycle");

    a_holdoff_idle: assert property ((st_r == WTC_ST_HOLD) && (cnt_r > 23'h1)
        |-> ##1 !wave_start_r ##1 !wave_start_r)
        else $error("output started during holdoff");

    a_timer_block: assert property ((src_sel == WTC_SRC_TIMER) && (timer_mode == WTC_TMR_OFF)
        && (st_r == WTC_ST_IDLE) |=> (st_r == WTC_ST_IDLE) && !wave_start_r)
        else $error("trigger accepted while the timer source was selected");

    a_trig_one_cycle: assert property ((st_r == WTC_ST_PLAY) && trig_mode && cycle_done
        && (burst_r == 20'h1) && !retrig_on && !(acc_any && ovr_ok)
        |=> !playing_r && hold_last_r && !wave_start_r)
        else $error("triggered mode did not stop after its cycle");

endmodule

// ### core/wtc_map.svh
`ifndef WTC_MAP_SVH
`define WTC_MAP_SVH

// Sample clock
`define WTC_CLK_HZ        10000000
`define WTC_CLK_NS        100

// Start-to-start timer limits
`define WTC_TIMER_MIN_NS  200
`define WTC_TIMER_MIN_CYC ((`WTC_TIMER_MIN_NS + `WTC_CLK_NS - 1) / `WTC_CLK_NS)
`define WTC_TIMER_MAX_S   20
`define WTC_TIMER_MAX_CYC (`WTC_TIMER_MAX_S * `WTC_CLK_HZ)

// Counted limits, in sample clock periods or output cycles
`define WTC_DELAY_MAX     8000000
`define WTC_RETRIG_MIN    152
`define WTC_RETRIG_MAX    8000000
`define WTC_BURST_MIN     1
`define WTC_BURST_MAX     1000000

// Reset values
`define WTC_RST_STATE     3'h0

`endif

// ### core/wtc_pkg.sv
package wtc_pkg;

    typedef enum logic [1:0] {
        WTC_RUN_CONT = 2'b00,
        WTC_RUN_TRIG = 2'b01,
        WTC_RUN_GATE = 2'b10
    } wtc_run_t;

    typedef enum logic [1:0] {
        WTC_SRC_EXT   = 2'b00,
        WTC_SRC_BUS   = 2'b01,
        WTC_SRC_EVENT = 2'b10,
        WTC_SRC_TIMER = 2'b11
    } wtc_src_t;

    typedef enum logic [1:0] {
        WTC_EDGE_RISE = 2'b00,
        WTC_EDGE_FALL = 2'b01,
        WTC_EDGE_BOTH = 2'b10
    } wtc_edge_t;

    typedef enum logic [1:0] {
        WTC_WID_OFF      = 2'b00,
        WTC_WID_WIDER    = 2'b01,
        WTC_WID_NARROWER = 2'b10,
        WTC_WID_BETWEEN  = 2'b11
    } wtc_width_t;

    typedef enum logic [1:0] {
        WTC_TMR_OFF   = 2'b00,
        WTC_TMR_START = 2'b01,
        WTC_TMR_STOP  = 2'b10
    } wtc_tmode_t;

    typedef enum logic [2:0] {
        WTC_ST_IDLE  = 3'b000,
        WTC_ST_HOLD  = 3'b001,
        WTC_ST_ARMED = 3'b010,
        WTC_ST_DELAY = 3'b011,
        WTC_ST_PLAY  = 3'b100,
        WTC_ST_GAP   = 3'b101
    } wtc_state_t;

endpackage

// ### core/wtc_width_qual.sv
`timescale 1ns/1ps
module wtc_width_qual #(
    parameter int W = 16
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                en,
    input  wire logic                sig,
    input  wire wtc_pkg::wtc_edge_t  edge_sel,
    input  wire wtc_pkg::wtc_width_t width_mode,
    input  wire logic [W-1:0]        width_lo,
    input  wire logic [W-1:0]        width_hi,
    output logic                     hit_r
);
    import wtc_pkg::*;

    logic         prev_r;
    logic         prev_nxt;
    logic         meas_r;
    logic         meas_nxt;
    logic         hit_nxt;
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         rise;
    logic         fall;
    logic         open_e;
    logic         close_e;
    logic         fits;

    always_comb begin
        rise    = sig & ~prev_r;
        fall    = ~sig & prev_r;
        open_e  = (edge_sel == WTC_EDGE_FALL) ? fall : rise;
        close_e = (edge_sel == WTC_EDGE_FALL) ? rise : fall;
        unique case (width_mode)
            WTC_WID_OFF:      fits = 1'b0;
            WTC_WID_WIDER:    fits = (cnt_r > width_lo);
            WTC_WID_NARROWER: fits = (cnt_r < width_lo);
            WTC_WID_BETWEEN:  fits = (cnt_r > width_lo) && (cnt_r < width_hi);
        endcase
        prev_nxt = sig;
        meas_nxt = meas_r;
        cnt_nxt  = cnt_r;
        hit_nxt  = 1'b0;
        // Disabled input is ignored before any edge is looked at
        if (!en) begin
            meas_nxt = 1'b0;
            cnt_nxt  = '0;
        end else if (width_mode == WTC_WID_OFF) begin
            unique case (edge_sel)
                WTC_EDGE_RISE: hit_nxt = rise;
                WTC_EDGE_FALL: hit_nxt = fall;
                WTC_EDGE_BOTH: hit_nxt = rise | fall;
                default:       hit_nxt = 1'b0;
            endcase
        end else if (open_e) begin
            meas_nxt = 1'b1;
            cnt_nxt  = {{(W-1){1'b0}}, 1'b1};
        end else if (meas_r && close_e) begin
            meas_nxt = 1'b0;
            hit_nxt  = fits;
        end else if (meas_r && (cnt_r != '1)) begin
            // Saturates so a very long pulse still reads as wider than any limit below all ones
            cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prev_r <= 1'b0;
            meas_r <= 1'b0;
            cnt_r  <= '0;
            hit_r  <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            meas_r <= meas_nxt;
            cnt_r  <= cnt_nxt;
            hit_r  <= hit_nxt;
        end
    end

endmodule

// ### verif/wtc_play_model.sv
`timescale 1ns/1ps
module wtc_play_model #(
    parameter int LEN = 10
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic wave_start_r,
    output logic      cycle_done
);
    int cnt_r;
    // Every start replays from sample zero, so an override only reloads the count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            cnt_r <= 0;
        else if (wave_start_r)
            cnt_r <= LEN;
        else if (cnt_r > 0)
            cnt_r <= cnt_r - 1;
    end
    assign cycle_done = (cnt_r == 1);
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    import wtc_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, trig_in_pin = 1'b0, event_in_pin = 1'b0;
    logic        manual_trigger_button = 1'b0, bus_trigger = 1'b0, event_fall = 1'b0, arm_en = 1'b0;
    logic        override_en = 1'b0, seq_playing = 1'b0, holdoff_en = 1'b0, cycle_done;
    logic        wave_start_r, playing_r, out_enable_r, hold_last_r;
    wtc_run_t    run_mode = WTC_RUN_TRIG;
    wtc_src_t    src_sel = WTC_SRC_BUS;
    wtc_edge_t   trig_edge = WTC_EDGE_RISE;
    wtc_width_t  width_mode = WTC_WID_OFF;
    wtc_tmode_t  timer_mode = WTC_TMR_OFF;
    logic [15:0] width_lo = 16'h4, width_hi = 16'h8;
    logic [22:0] holdoff_cycles = 23'h5, start_delay = 23'h0, retrig_delay = 23'h98;
    logic [27:0] timer_period = 28'h14;
    logic [19:0] burst_count = 20'h1;
    int          n_start = 0, n_fail = 0, total_checks = 0;

    wtc_trigger_ctrl #(
        .DELAY_MAX     (23'h190),
        .RETRIG_MAX    (23'h190),
        .BURST_MAX     (20'h8),
        .TIMER_MAX_CYC (28'h64)
    ) u_dut (
        .clk_sys               (clk_sys),
        .rst                   (rst),
        .trig_in_pin           (trig_in_pin),
        .event_in_pin          (event_in_pin),
        .manual_trigger_button (manual_trigger_button),
        .bus_trigger           (bus_trigger),
        .run_mode              (run_mode),
        .src_sel               (src_sel),
        .trig_edge             (trig_edge),
        .event_fall            (event_fall),
        .arm_en                (arm_en),
        .override_en           (override_en),
        .seq_playing           (seq_playing),
        .width_mode            (width_mode),
        .width_lo              (width_lo),
        .width_hi              (width_hi),
        .holdoff_en            (holdoff_en),
        .holdoff_cycles        (holdoff_cycles),
        .start_delay           (start_delay),
        .timer_mode            (timer_mode),
        .timer_period          (timer_period),
        .retrig_delay          (retrig_delay),
        .burst_count           (burst_count),
        .cycle_done            (cycle_done),
        .wave_start_r          (wave_start_r),
        .playing_r             (playing_r),
        .out_enable_r          (out_enable_r),
        .hold_last_r           (hold_last_r)
    );
    wtc_play_model u_play (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .wave_start_r (wave_start_r),
        .cycle_done   (cycle_done)
    );

    initial forever #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wave_start_r === 1'b1) n_start++;

    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Kinds: 0 remote command, 1 front pin toggle, 2 button press, 3 event pin toggle
    task automatic hit(input int k);
        case (k)
            0: bus_trigger = 1'b1;
            1: trig_in_pin = ~trig_in_pin;
            2: manual_trigger_button = 1'b1;
            default: event_in_pin = ~event_in_pin;
        endcase
        step(1);
        bus_trigger = 1'b0;
        manual_trigger_button = 1'b0;
    endtask
    // Window covers sync latency plus a full burst of the short model waveform
    task automatic go(input int k, input int exp);
        int s;
        s = n_start;
        hit(k);
        step(45);
        chk(n_start - s, exp);
    endtask
    // Front pin pulse of n sample clocks; the synchroniser keeps its width
    task automatic wid(input int n, input int exp);
        int s;
        s = n_start;
        trig_in_pin = 1'b1;
        step(n);
        trig_in_pin = 1'b0;
        step(45);
        chk(n_start - s, exp);
    endtask
    task automatic span(input int n, input int exp);
        int s;
        s = n_start;
        step(n);
        chk(n_start - s, exp);
    endtask

    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        step(12);
        rst = 1'b0;
        step(2);
        hit(0);
        chk(wave_start_r, 1);
        chk(hold_last_r, 0);
        chk(playing_r, 1);
        chk(out_enable_r, 1);
        step(20);
        chk(hold_last_r, 1);
        chk(playing_r, 0);
        chk(out_enable_r, 0);
        start_delay = 23'h5;
        hit(0);
        step(4);
        chk(wave_start_r, 0);
        step(1);
        chk(wave_start_r, 1);
        step(20);
        start_delay = 23'h0;
        burst_count = 20'h3;
        go(0, 3);
        burst_count = 20'h1;
        $display("test delay_burst done");
        for (int i = 0; i < 3; i++) begin
            override_en = (i > 0);
            seq_playing = (i == 2);
            hit(0);
            step(3);
            go(0, i == 1);
        end
        override_en = 1'b0;
        seq_playing = 1'b0;
        $display("test override done");
        src_sel = WTC_SRC_EXT;
        go(0, 0);
        go(2, 1);
        for (int e = 0; e < 3; e++) begin
            trig_edge = wtc_edge_t'(e);
            go(1, e != 1);
            go(1, e != 0);
        end
        trig_edge = WTC_EDGE_RISE;
        width_mode = WTC_WID_WIDER;
        wid(6, 1);
        wid(3, 0);
        width_mode = WTC_WID_NARROWER;
        wid(3, 1);
        wid(6, 0);
        width_mode = WTC_WID_BETWEEN;
        wid(6, 1);
        wid(8, 0);
        width_mode = WTC_WID_OFF;
        $display("test width done");
        src_sel = WTC_SRC_EVENT;
        for (int f = 0; f < 2; f++) begin
            event_fall = f[0];
            go(3, f == 0);
            go(3, f == 1);
        end
        src_sel = WTC_SRC_BUS;
        go(1, 0);
        go(2, 0);
        go(3, 0);
        run_mode = WTC_RUN_GATE;
        go(0, 0);
        run_mode = WTC_RUN_TRIG;
        $display("test sources done");
        run_mode = WTC_RUN_CONT;
        src_sel = WTC_SRC_EVENT;
        step(2);
        chk(out_enable_r, 1);
        arm_en = 1'b1;
        step(2);
        chk(out_enable_r, 0);
        // Pick the slope that the next toggle of the event pin makes
        event_fall = event_in_pin;
        hit(3);
        step(4);
        chk(out_enable_r, 1);
        run_mode = WTC_RUN_GATE;
        src_sel = WTC_SRC_EXT;
        trig_edge = WTC_EDGE_BOTH;
        arm_en = 1'b0;
        hit(1);
        step(4);
        chk(out_enable_r, 1);
        hit(1);
        step(4);
        chk(out_enable_r, 0);
        $display("test run modes done");
        run_mode = WTC_RUN_TRIG;
        src_sel = WTC_SRC_TIMER;
        // Period of 20 clocks stays longer than the 10-clock model waveform
        timer_mode = WTC_TMR_START;
        span(99, 4);
        timer_mode = WTC_TMR_OFF;
        go(0, 0);
        timer_mode = WTC_TMR_STOP;
        span(200, 2);
        timer_mode = WTC_TMR_OFF;
        step(150);
        src_sel = WTC_SRC_BUS;
        $display("test timer done");
        holdoff_en = 1'b1;
        go(0, 0);
        go(0, 1);
        $display("test holdoff done");
        tally_and_finish;
    end
endmodule
